/* File: hdl/vhi_host_if.v */
// vhi_host_if.v: host vme interface - window map, modifier generation, slave decode,
// bus timer and slot arbitration. assumes all inputs sync to sys_clk, strobes active high.
// Notes on behaviour
// [R1] master drives six-bit modifier with address
// [R2] modifier encodes width, block, privilege
// [R3] host makes modifier for processor cycles
// [R4] processor C1000000..F0000000 maps above 80000000; code maps only C1000000..E0F3FFFF, the rest is flagged
// [R5] A32 window offset-preserving translation
// [R6] A24 window offset-preserving translation
// [R7] A16 window offset-preserving translation
// [R8] accept listed A32 master modifiers only
// [R9] accept listed A24 master modifiers only
// [R10] slave answers within 64 microseconds
// [R11] timeout asserts bus error, system fault
// [R12] per-slot request and direct grant
// [R13] grant then bus busy until release
// [R14] no bus clear to current master
// [R15] all four request levels honoured
// [R16] priority, round robin, release-on-request combinable
// [R17] reset default straight slot priority
// [R18] scheme held in processor read/write register
// [R19] short, standard, extended per cycle
// [R20] block aligned; single width alignment rules
// [R21] unmapped or unlisted accesses ignored
`include "vhi_defines.vh"
module vhi_host_if
(
  input wire sys_clk,
  input wire rst,
  // processor side
  input wire cpu_req,
  input wire [31:0] cpu_addr,
  input wire cpu_wr,
  input wire [1:0] cpu_size,
  input wire cpu_blk,
  input wire cpu_sup,
  output reg cpu_ack_q,
  output reg cpu_err_q,
  output reg cpu_bad_q,
  // arbitration scheme register
  input wire cfg_wr,
  input wire [`VHI_ARB_W-1:0] cfg_wdata,
  output reg [`VHI_ARB_W-1:0] cfg_rdata_q,
  input wire [`VHI_SLOTS-1:0] rr_slots,
  input wire [`VHI_SLOTS-1:0] cpu_slots,
  // vme master side
  output reg [31:0] vme_addr_q,
  output reg [5:0] vme_am_q,
  output reg vme_as_q,
  output reg vme_ds_q,
  output reg vme_write_q,
  output reg vme_bbsy_q,
  input wire vme_dtack,
  input wire vme_berr_in,
  output reg vme_berr_q,
  output reg sys_fault_q,
  // vme slave side
  input wire slv_as,
  input wire [31:0] slv_addr,
  input wire [5:0] slv_am,
  output reg slv_sel_q,
  output reg [31:0] slv_local_q,
  // arbitration
  input wire [`VHI_SLOTS*`VHI_LEVELS-1:0] bus_req,
  input wire bus_bbsy,
  output reg [`VHI_SLOTS*`VHI_LEVELS-1:0] bus_grant_q,
  output reg host_grant_q
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ARB = 3'd1;
  localparam ST_CYC = 3'd2;
  localparam ST_DONE = 3'd3;
  localparam ST_BERR = 3'd4;
  localparam [31:0] TOUT_FULL = `VHI_TOUT_CYC;
  localparam [`VHI_TMR_W-1:0] TOUT = TOUT_FULL[`VHI_TMR_W-1:0];

  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [`VHI_TMR_W-1:0] tmr_q;
  reg [`VHI_ARB_W-1:0] arb_q;
  reg [31:0] lat_addr_q;
  reg [1:0] lat_cls_q;
  reg lat_blk_q;
  reg lat_sup_q;
  reg lat_wr_q;
  wire [`VHI_SLOTS*`VHI_LEVELS-1:0] arb_grant;
  wire arb_busy;

  // window class: 0 none, 1 A16, 2 A24, 3 A32
  function [1:0] win_class;
    input [31:0] a;
    begin
      if (a >= `VHI_A16_LO && a <= `VHI_A16_HI)
        win_class = 2'd1; // [R7]
      else if (a >= `VHI_A32_LO && a <= `VHI_A32_HI)
        win_class = 2'd3; // [R5]
      else if (a >= `VHI_A24_LO && a <= `VHI_A24_HI)
        win_class = 2'd2; // [R6]
      else
        win_class = 2'd0; // [R21]
    end
  endfunction

  // translated address keeps the offset inside the window [R4]
  function [31:0] xlate;
    input [31:0] a;
    input [1:0] c;
    begin
      case (c)
        2'd1: xlate = a - `VHI_A16_LO + `VHI_A16_VME; // [R7]
        2'd2: xlate = a - `VHI_A24_LO + `VHI_A24_VME; // [R6]
        2'd3: xlate = a - `VHI_A32_LO + `VHI_A32_VME; // [R5]
        default: xlate = 32'h00000000;
      endcase
    end
  endfunction

  // one modifier per transfer type: width class, block, privilege [R1] [R2] [R19]
  function [5:0] am_gen;
    input [1:0] c;
    input b;
    input p;
    begin
      case ({c, b, p})
        4'b0100: am_gen = `VHI_AM_A16_USR;
        4'b0101: am_gen = `VHI_AM_A16_SUP;
        4'b1000: am_gen = `VHI_AM_A24_USR;
        4'b1001: am_gen = `VHI_AM_A24_SUP;
        4'b1010: am_gen = `VHI_AM_A24_BLK_USR;
        4'b1011: am_gen = `VHI_AM_A24_BLK_SUP;
        4'b1100: am_gen = `VHI_AM_A32_USR;
        4'b1101: am_gen = `VHI_AM_A32_SUP;
        4'b1110: am_gen = `VHI_AM_A32_BLK_USR;
        4'b1111: am_gen = `VHI_AM_A32_BLK_SUP;
        default: am_gen = `VHI_AM_A16_SUP;
      endcase
    end
  endfunction

  // alignment: block longword only; word even; longword on four [R20]
  function aligned;
    input [31:0] a;
    input [1:0] sz;
    input b;
    begin
      if (b)
        aligned = (a[1:0] == 2'b00) && (sz == 2'd2);
      else if (sz == 2'd1)
        aligned = (a[0] == 1'b0);
      else if (sz == 2'd2)
        aligned = (a[1:0] == 2'b00);
      else
        aligned = (sz == 2'd0);
    end
  endfunction

  // slave decode of an external master access [R8] [R9]
  function slv_hit;
    input [31:0] a;
    input [5:0] m;
    begin
      case (m)
        6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F:
          slv_hit = (a <= `VHI_SLV32_HI); // [R8]
        6'h38, 6'h39, 6'h3A, 6'h3C, 6'h3D, 6'h3E:
          slv_hit = (a[23:0] <= `VHI_SLV24_HI); // [R9]
        default:
          slv_hit = 1'b0; // [R21]
      endcase
    end
  endfunction

  wire [1:0] cls = win_class(cpu_addr);
  wire cpu_ok = (cls != 2'd0) && aligned(cpu_addr, cpu_size, cpu_blk);
  wire host_req = (st_q == ST_ARB);

  vhi_arbiter u_arb
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(bus_req),
    .rr_slots(rr_slots),
    .cpu_slots(cpu_slots),
    .rr_en(arb_q[`VHI_ARB_RR_BIT]), // [R16]
    .bbsy_in(bus_bbsy | vme_bbsy_q),
    .grant_q(arb_grant),
    .busy_q(arb_busy)
  );

  // scheme register, straight priority after reset [R18] [R17]
  always @(posedge sys_clk)
  begin
    if (rst)
      arb_q <= `VHI_ARB_RST;
    else if (cfg_wr)
      arb_q <= cfg_wdata; // [R16]
  end

  // host gets the bus when no slot holds it and either none waits or the host bit is set; with release-on-request it also
  // drops bus busy between cycles if a slot is waiting
  wire slot_wait = |bus_req;
  wire host_win = !arb_busy && !bus_bbsy && (arb_q[`VHI_ARB_HOST_BIT] || !slot_wait); // [R13]

  always @*
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (cpu_req && cpu_ok)
          st_d = ST_ARB;
      ST_ARB:
        if (host_win || vme_bbsy_q)
          st_d = ST_CYC;
      ST_CYC:
        if (vme_dtack)
          st_d = ST_DONE;
        else if (vme_berr_in || tmr_q == TOUT - 1)
          st_d = ST_BERR; // [R11]
      ST_DONE:
        st_d = ST_IDLE;
      ST_BERR:
        st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      tmr_q <= 10'h000;
      lat_addr_q <= 32'h00000000;
      lat_cls_q <= 2'd0;
      lat_blk_q <= 1'b0;
      lat_sup_q <= 1'b0;
      lat_wr_q <= 1'b0;
      vme_addr_q <= 32'h00000000;
      vme_am_q <= 6'h00;
      vme_as_q <= 1'b0;
      vme_ds_q <= 1'b0;
      vme_write_q <= 1'b0;
      vme_bbsy_q <= 1'b0;
      vme_berr_q <= 1'b0;
      sys_fault_q <= 1'b0;
      cpu_ack_q <= 1'b0;
      cpu_err_q <= 1'b0;
      cpu_bad_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cpu_ack_q <= 1'b0;
      cpu_err_q <= 1'b0;
      vme_berr_q <= 1'b0;
      sys_fault_q <= 1'b0;
      // unmapped or misaligned processor access is flagged, never forwarded
      cpu_bad_q <= (st_q == ST_IDLE) && cpu_req && !cpu_ok; // [R21]
      if (st_q == ST_IDLE && cpu_req && cpu_ok)
      begin
        lat_addr_q <= cpu_addr;
        lat_cls_q <= cls;
        lat_blk_q <= cpu_blk;
        lat_sup_q <= cpu_sup;
        lat_wr_q <= cpu_wr;
      end
      if (st_q == ST_ARB && st_d == ST_CYC)
      begin
        vme_bbsy_q <= 1'b1; // [R13]
        vme_addr_q <= xlate(lat_addr_q, lat_cls_q); // [R4]
        vme_am_q <= am_gen(lat_cls_q, lat_blk_q, lat_sup_q); // [R3]
        vme_write_q <= lat_wr_q;
        vme_as_q <= 1'b1;
        vme_ds_q <= 1'b1;
      end
      // bus timer runs only while strobes wait for acknowledge [R10]
      if (st_q == ST_CYC)
        tmr_q <= tmr_q + 10'h001;
      else
        tmr_q <= 10'h000;
      if ((st_q == ST_CYC) && (st_d != ST_CYC))
      begin
        vme_as_q <= 1'b0;
        vme_ds_q <= 1'b0;
        cpu_ack_q <= (st_d == ST_DONE);
        cpu_err_q <= (st_d == ST_BERR);
        vme_berr_q <= (st_d == ST_BERR); // [R11]
        sys_fault_q <= (st_d == ST_BERR); // [R11]
        // release the bus when a slot waits and release-on-request is chosen
        if (arb_q[`VHI_ARB_ROR_BIT] && slot_wait)
          vme_bbsy_q <= 1'b0; // [R16]
      end
      if (st_q == ST_IDLE && !cpu_req)
        vme_bbsy_q <= 1'b0;
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      slv_sel_q <= 1'b0;
      slv_local_q <= 32'h00000000;
      bus_grant_q <= 16'h0000;
      host_grant_q <= 1'b0;
      cfg_rdata_q <= `VHI_ARB_RST;
    end
    else
    begin
      slv_sel_q <= slv_as && slv_hit(slv_addr, slv_am); // [R8] [R9]
      slv_local_q <= (slv_am[5:4] == 2'b11) ? {8'h00, slv_addr[23:0]} : slv_addr;
      bus_grant_q <= arb_grant; // [R12]
      host_grant_q <= vme_bbsy_q;
      cfg_rdata_q <= arb_q; // [R18]
    end
  end
endmodule // vhi_host_if

/* File: hdl/vhi_defines.vh */
// vhi_defines.vh: constants for the host vme interface (windows, modifiers, timing)
// assumes: included by vhi design files only; definitions only
`ifndef VHI_DEFINES_VH
`define VHI_DEFINES_VH
`define VHI_A16_LO 32'hC1000000
`define VHI_A16_HI 32'hC100FFFF
`define VHI_A16_VME 32'hFFFF0000
`define VHI_A32_LO 32'hC1010000
`define VHI_A32_HI 32'hE0BFFFFF
`define VHI_A32_VME 32'hE0010000
`define VHI_A24_LO 32'hE0C00000
`define VHI_A24_HI 32'hE0F3FFFF
`define VHI_A24_VME 32'hFFC00000
`define VHI_MAP_LO 32'hC1000000
`define VHI_MAP_HI 32'hF0000000
`define VHI_VME_MAP_MIN 32'h80000000
`define VHI_SLV32_HI 32'h7FFFFFFF
`define VHI_SLV24_HI 24'hBFFFFF
`define VHI_AM_W 6
// modifiers generated for processor cycles (supervisory or user data, single location or block)
`define VHI_AM_A32_SUP 6'h0D
`define VHI_AM_A24_SUP 6'h3D
`define VHI_AM_A16_SUP 6'h2D
`define VHI_AM_A32_USR 6'h09
`define VHI_AM_A24_USR 6'h39
`define VHI_AM_A16_USR 6'h29
`define VHI_AM_A32_BLK_SUP 6'h0F
`define VHI_AM_A24_BLK_SUP 6'h3F
`define VHI_AM_A32_BLK_USR 6'h0B
`define VHI_AM_A24_BLK_USR 6'h3B
// bus timer
`define VHI_CLK_HZ 10000000
`define VHI_TOUT_US 64
`define VHI_TOUT_CYC ((`VHI_TOUT_US * (`VHI_CLK_HZ / 1000000)))
`define VHI_TMR_W 10
// arbiter
`define VHI_SLOTS 4
`define VHI_LEVELS 4
`define VHI_ARB_W 4
`define VHI_ARB_RST 4'h0
`define VHI_ARB_PRI_BIT 0
`define VHI_ARB_RR_BIT 1
`define VHI_ARB_ROR_BIT 2
`define VHI_ARB_HOST_BIT 3
`endif

/* File: hdl/vhi_arbiter.v */
// vhi_arbiter.v: slot arbiter with direct grant per slot and four request levels
// assumes: requests are sync to sys_clk; bbsy_in high while any master holds the bus
`include "vhi_defines.vh"
module vhi_arbiter
(
  input wire sys_clk,
  input wire rst,
  input wire [`VHI_SLOTS*`VHI_LEVELS-1:0] req,
  input wire [`VHI_SLOTS-1:0] rr_slots,
  input wire [`VHI_SLOTS-1:0] cpu_slots,
  input wire rr_en,
  input wire bbsy_in,
  output reg [`VHI_SLOTS*`VHI_LEVELS-1:0] grant_q,
  output reg busy_q
);
  reg [1:0] last_q;
  reg [1:0] win;
  reg found;
  reg [`VHI_SLOTS-1:0] any_req;
  reg [1:0] rr_idx;
  integer s;
  integer l;
  integer k;
  reg [1:0] lvl [0:`VHI_SLOTS-1];
  always @*
  begin
    for (s = 0; s < `VHI_SLOTS; s = s + 1)
    begin
      any_req[s] = 1'b0;
      lvl[s] = 2'd0;
      // level 0 preferred, higher levels still honoured
      for (l = `VHI_LEVELS-1; l >= 0; l = l - 1)
        if (req[s*`VHI_LEVELS+l])
        begin
          any_req[s] = 1'b1; // [R15]
          lvl[s] = l[1:0];
        end
    end
    found = 1'b0;
    win = 2'd0;
    rr_idx = 2'd0;
    // round robin among marked slots starting after last winner
    // two-bit index wraps by itself, so no modulo and no wide result
    if (rr_en)
      for (k = 1; k <= `VHI_SLOTS; k = k + 1)
      begin
        rr_idx = last_q + k[1:0];
        if (!found && any_req[rr_idx] && rr_slots[rr_idx])
        begin
          found = 1'b1; // [R12]
          win = rr_idx;
        end
      end
    // straight priority, lowest non-processor slot first
    for (s = 0; s < `VHI_SLOTS; s = s + 1)
      if (!found && any_req[s] && !cpu_slots[s])
      begin
        found = 1'b1; // [R17]
        win = s[1:0];
      end
    for (s = 0; s < `VHI_SLOTS; s = s + 1)
      if (!found && any_req[s])
      begin
        found = 1'b1;
        win = s[1:0];
      end
  end
  // no bus clear: a master is never asked to let go early
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      grant_q <= 16'h0000;
      busy_q <= 1'b0;
      last_q <= 2'd3;
    end
    else if (busy_q)
    begin
      // grant holds until the master drops request and bus busy [R13] [R14]
      if (!bbsy_in && (grant_q & req) == 16'h0000)
      begin
        busy_q <= 1'b0;
        grant_q <= 16'h0000;
      end
    end
    else if (found && !bbsy_in)
    begin
      grant_q <= 16'h0001 << {win, lvl[win]}; // [R12]
      busy_q <= 1'b1;
      last_q <= win;
    end
  end
endmodule // vhi_arbiter

/* File: verif/vhi_host_if_asserts.sv */
// vhi_host_if_asserts.sv: port checker for vhi_host_if
// assumes: one clock, rst synchronous active high, bound below
module vhi_host_if_asserts
(
  input wire sys_clk,
  input wire rst,
  input wire cpu_ack_q,
  input wire vme_as_q,
  input wire vme_bbsy_q,
  input wire [31:0] vme_addr_q,
  input wire [5:0] vme_am_q,
  input wire vme_dtack,
  input wire vme_berr_q,
  input wire sys_fault_q,
  input wire slv_as,
  input wire [31:0] slv_addr,
  input wire [5:0] slv_am,
  input wire slv_sel_q,
  input wire [15:0] bus_req,
  input wire [15:0] bus_grant_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] wait_q;
  logic ok32;
  logic ok24;
  assign ok32 = slv_am[5:3] == 3'h1 && !slv_addr[31];
  assign ok24 = slv_am[5:3] == 3'h7 && slv_am[1:0] != 2'h3 && slv_addr[23:0] <= 24'hBFFFFF;
  // strobe cycles without acknowledge, as the bus timer should see them
  always @(posedge sys_clk)
    if (rst || !vme_as_q || vme_dtack)
      wait_q <= 11'h000;
    else
      wait_q <= wait_q + 11'h001;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_AS_BBSY: assert property (vme_as_q |-> vme_bbsy_q) else $error("strobe without busy");
  AST_MAP_HIGH: assert property ($rose(vme_as_q) |-> vme_addr_q >= 32'h80000000) else $error("low vme address");
  AST_AM_CLASS:
    assert property ($rose(vme_as_q) |-> vme_am_q[5:3] == (vme_addr_q >= 32'hFFFF0000 ? 3'h5 :
      (vme_addr_q >= 32'hFFC00000 ? 3'h7 : 3'h1))) else $error("modifier class wrong");
  AST_ACK: assert property ($rose(vme_dtack) && vme_as_q |-> ##[1:2] cpu_ack_q) else $error("no ack");
  AST_TOUT: assert property (wait_q == 11'd640 |-> ##[0:3] vme_berr_q) else $error("no bus error");
  AST_FAULT:
    assert property ($rose(vme_berr_q) |-> wait_q >= 11'd630 ##[0:1] sys_fault_q) else $error("bad fault timing");
  AST_SLV32: assert property (slv_as && ok32 |=> slv_sel_q) else $error("a32 access refused");
  AST_SLV24: assert property (slv_as && ok24 |=> slv_sel_q) else $error("a24 access refused");
  AST_SLV_REJ: assert property (slv_as && !ok32 && !ok24 |=> !slv_sel_q) else $error("access taken");
  AST_ONEHOT: assert property ($onehot0(bus_grant_q)) else $error("several grants");
  AST_GRANT_REQ:
    assert property (|bus_grant_q && !$past(|bus_grant_q) |-> |(bus_grant_q & $past(bus_req)))
      else $error("grant without request");
  cover property ($rose(vme_berr_q));
  cover property ($rose(cpu_ack_q));
  cover property (slv_as && ok24 ##1 slv_sel_q);
endmodule // vhi_host_if_asserts

bind vhi_host_if vhi_host_if_asserts u_chk (.sys_clk(sys_clk), .rst(rst), .cpu_ack_q(cpu_ack_q),
  .vme_as_q(vme_as_q), .vme_bbsy_q(vme_bbsy_q), .vme_addr_q(vme_addr_q), .vme_am_q(vme_am_q),
  .vme_dtack(vme_dtack), .vme_berr_q(vme_berr_q), .sys_fault_q(sys_fault_q), .slv_as(slv_as),
  .slv_addr(slv_addr), .slv_am(slv_am), .slv_sel_q(slv_sel_q), .bus_req(bus_req), .bus_grant_q(bus_grant_q));

/* File: verif/vhi_slave_model.sv */
// vhi_slave_model.sv: behavioural vme slave answering host cycles
// assumes: strobes active high; dtack held until the strobes drop
module vhi_slave_model
(
  input wire sys_clk,
  input wire vme_as,
  input wire vme_ds,
  input wire [9:0] delay,
  input wire mute,
  output logic vme_dtack
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial vme_dtack = 1'b0;
  // mute stands for a dead slave, the only wrong answer the bench orders
  always @(posedge sys_clk)
  begin
    cnt <= (vme_as && vme_ds) ? cnt + 1 : 0;
    vme_dtack <= vme_as && vme_ds && !mute && cnt + 1 > delay;
  end
endmodule // vhi_slave_model

/* File: verif/testbench.sv */
// testbench.sv: self-checking bench for vhi_host_if
// assumes: bound checker and slave model; inputs change at falling edge
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst, cpu_req, cpu_blk, cpu_sup, cfg_wr, slv_as, bus_bbsy, mute, cpu_wr;
  logic [31:0] cpu_addr, slv_addr;
  logic [1:0] cpu_size;
  logic [3:0] cfg_wdata, cpu_slots, rr_slots;
  logic [5:0] slv_am;
  logic [15:0] bus_req;
  logic [9:0] delay;
  wire cpu_ack_q, cpu_err_q, cpu_bad_q, vme_as_q, vme_ds_q, vme_bbsy_q, vme_dtack, vme_berr_q;
  wire sys_fault_q, slv_sel_q, host_grant_q, vme_write_q;
  wire [3:0] cfg_rdata_q;
  wire [31:0] vme_addr_q, slv_local_q;
  wire [5:0] vme_am_q;
  wire [15:0] bus_grant_q;
  int err_total = 0;
  int total_checks = 0;
  vhi_host_if dut (.sys_clk(sys_clk), .rst(rst), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_size(cpu_size), .cpu_blk(cpu_blk), .cpu_sup(cpu_sup), .cpu_ack_q(cpu_ack_q), .cpu_err_q(cpu_err_q),
    .cpu_bad_q(cpu_bad_q), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .rr_slots(rr_slots), .cpu_slots(cpu_slots), .vme_addr_q(vme_addr_q), .vme_am_q(vme_am_q),
    .vme_as_q(vme_as_q), .vme_ds_q(vme_ds_q), .vme_write_q(vme_write_q), .vme_bbsy_q(vme_bbsy_q),
    .vme_dtack(vme_dtack), .vme_berr_in(1'b0), .vme_berr_q(vme_berr_q), .sys_fault_q(sys_fault_q),
    .slv_as(slv_as), .slv_addr(slv_addr), .slv_am(slv_am), .slv_sel_q(slv_sel_q), .slv_local_q(slv_local_q),
    .bus_req(bus_req), .bus_bbsy(bus_bbsy), .bus_grant_q(bus_grant_q), .host_grant_q(host_grant_q));
  vhi_slave_model u_slave (.sys_clk(sys_clk), .vme_as(vme_as_q), .vme_ds(vme_ds_q), .delay(delay),
    .mute(mute), .vme_dtack(vme_dtack));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
  begin
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  function automatic logic pick(int sel);
    case (sel)
      0: pick = vme_as_q;
      1: pick = cpu_ack_q;
      2: pick = cpu_err_q;
      3: pick = cpu_bad_q;
      default: pick = bus_grant_q[sel];
    endcase
  endfunction
  // bounded wait so a silent design cannot stall a scenario
  task automatic wait_on(int sel, int lim, output int n);
  begin
    n = 0;
    while (pick(sel) !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
  end
  endtask
  task automatic cpu_go(logic [31:0] a, logic b, logic s);
  begin
    cpu_addr = a;
    cpu_blk = b;
    cpu_sup = s;
    cpu_req = 1'b1;
  end
  endtask
  task automatic cpu_cycle(logic [31:0] a, logic b, logic s, logic [31:0] ea, logic [5:0] em);
    int n;
  begin
    cpu_go(a, b, s);
    wait_on(0, 20, n);
    check("vme address", ea, vme_addr_q);
    check("modifier", 32'(em), 32'(vme_am_q));
    check("data strobe", 1, vme_ds_q);
    check("write flag", 32'(cpu_wr), 32'(vme_write_q));
    wait_on(1, 80, n);
    check("cpu ack", 1, cpu_ack_q);
    check("host holds bus", 1, host_grant_q);
    cpu_req = 1'b0;
    @(negedge sys_clk);
  end
  endtask
  task automatic bad_try(logic [31:0] a);
    int n;
  begin
    cpu_go(a, 1'b0, 1'b1);
    wait_on(3, 5, n);
    check("refused flag", 1, cpu_bad_q);
    check("no strobe", 0, vme_as_q);
    cpu_req = 1'b0;
    @(negedge sys_clk);
  end
  endtask
  task automatic slv_try(logic [31:0] a, logic [5:0] m, logic e);
  begin
    slv_addr = a;
    slv_am = m;
    slv_as = 1'b1;
    @(negedge sys_clk);
    check("slave select", 32'(e), 32'(slv_sel_q));
    slv_as = 1'b0;
    @(negedge sys_clk);
  end
  endtask
  task automatic t_cpu;
  begin
    check("scheme after reset", 0, cfg_rdata_q);
    cpu_cycle(32'hC1000010, 0, 1, 32'hFFFF0010, 6'h2D);
    cpu_cycle(32'hC100FFFC, 0, 0, 32'hFFFFFFFC, 6'h29);
    cpu_cycle(32'hE0C00100, 0, 0, 32'hFFC00100, 6'h39);
    cpu_cycle(32'hE0F3FFFC, 1, 1, 32'hFFF3FFFC, 6'h3F);
    cpu_wr = 1'b1;
    cpu_cycle(32'hC1010004, 0, 1, 32'hE0010004, 6'h0D);
    cpu_wr = 1'b0;
    delay = 10'd40;
    cpu_cycle(32'hE0BFFFFC, 1, 0, 32'hFFBFFFFC, 6'h0B);
    delay = 10'd3;
    cpu_size = 2'h0;
    cpu_cycle(32'hC1000011, 0, 1, 32'hFFFF0011, 6'h2D);
    cpu_size = 2'h2;
    bad_try(32'hC0FFFFFC);
    bad_try(32'hE0F40000);
    bad_try(32'hC1010002);
    $display("test cpu windows done");
  end
  endtask
  task automatic t_timeout;
    int n;
  begin
    mute = 1'b1;
    cpu_go(32'hC1010100, 1'b0, 1'b1);
    wait_on(0, 20, n);
    wait_on(2, 700, n);
    check("timeout error", 1, cpu_err_q);
    check("bus error", 1, vme_berr_q);
    check("system fault", 1, sys_fault_q);
    check("timeout near 640", 1, 32'(n >= 630 && n <= 650));
    cpu_req = 1'b0;
    mute = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("strobe dropped", 0, vme_as_q);
    $display("test bus timer done");
  end
  endtask
  task automatic t_slave;
    logic [5:0] m;
  begin
    for (int i = 0; i < 64; i++)
    begin
      m = 6'(i);
      slv_try(32'h00001000, m, (m >= 6'h08 && m <= 6'h0F) ||
        m inside {6'h38, 6'h39, 6'h3A, 6'h3C, 6'h3D, 6'h3E});
    end
    slv_try(32'h7FFFFFFC, 6'h0F, 1);
    check("local address", 32'h7FFFFFFC, slv_local_q);
    slv_try(32'h80000000, 6'h09, 0);
    slv_try(32'h12BFFFFC, 6'h3D, 1);
    check("page offset", 32'h00BFFFFC, slv_local_q);
    slv_try(32'h00C00000, 6'h39, 0);
    $display("test slave decode done");
  end
  endtask
  task automatic t_arb;
    int n;
  begin
    cpu_slots = 4'b0001;
    bus_req = 16'h0111;
    wait_on(4, 6, n);
    check("lowest free slot", 16'h0010, bus_grant_q);
    bus_bbsy = 1'b1;
    bus_req = 16'h8101;
    repeat (4) @(negedge sys_clk);
    check("grant held", 16'h0010, bus_grant_q);
    check("host off bus", 0, vme_bbsy_q);
    bus_bbsy = 1'b0;
    wait_on(8, 6, n);
    check("next slot", 16'h0100, bus_grant_q);
    bus_req = 16'h8000;
    wait_on(15, 8, n);
    check("level three", 16'h8000, bus_grant_q);
    bus_req = 16'h0000;
    repeat (4) @(negedge sys_clk);
    cfg_wdata = 4'hA;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    @(negedge sys_clk);
    check("scheme readback", 4'hA, cfg_rdata_q);
    // slot 3 won last; with no processor slot straight priority would pick slot 0 twice
    cpu_slots = 4'h0;
    rr_slots = 4'h5;
    bus_req = 16'h0101;
    repeat (3) @(negedge sys_clk);
    check("round robin start", 16'h0001, bus_grant_q);
    bus_req = 16'h0000;
    repeat (2) @(negedge sys_clk);
    bus_req = 16'h0101;
    repeat (3) @(negedge sys_clk);
    check("round robin turn", 16'h0100, bus_grant_q);
    bus_req = 16'h0000;
    $display("test arbiter done");
  end
  endtask
  task automatic summarize;
  begin
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    {rst, cpu_req, cpu_blk, cpu_sup, cfg_wr, slv_as, bus_bbsy, mute} = 8'h80;
    {cpu_addr, slv_addr, slv_am, bus_req, cfg_wdata, cpu_slots, rr_slots, cpu_wr} = '0;
    cpu_size = 2'h2;
    delay = 10'd3;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_cpu;
    t_timeout;
    t_slave;
    t_arb;
    summarize;
  end
  // tests need about 900 cycles
  initial
  begin
    #(5000 * 100);
    err_total++;
    summarize;
  end
endmodule // testbench
